// ---- rtl/pfa_pkg.sv ----
// Constants and types for the frame alignment and clock select block
package pfa_pkg;

    typedef logic [7:0]  addr_t;
    typedef logic [31:0] data_t;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLOCK_CONTROL  = 8'h0b;
    localparam logic [7:0] IDX_SLIP_INTERVAL  = 8'h0c;
    localparam logic [7:0] IDX_RECEIVE_IN_OFS = 8'h0d;
    localparam logic [7:0] IDX_SEND_IN_OFS    = 8'h0e;
    localparam logic [7:0] IDX_SEND_OUT_OFS   = 8'h0f;
    localparam logic [7:0] IDX_AUX_OFS        = 8'h10;
    localparam logic [7:0] IDX_PHASE_OFS      = 8'h11;

    // Reset values
    localparam logic [6:0] RST_CLOCK_CONTROL = 7'h00;
    localparam logic [6:0] RST_SLIP_INTERVAL = 7'h28;
    localparam logic [7:0] RST_BIT_OFFSET    = 8'h00;
    localparam logic [7:0] RST_PHASE_OFS     = 8'h00;

    // Clock control field positions
    localparam int CC_VCO_INVERT     = 6;
    localparam int CC_SYNC_EDGE      = 5;
    localparam int CC_SYNC_OUT_LEN   = 4;
    localparam int CC_SAMPLE_EDGE    = 3;
    localparam int CC_VCO_OFF        = 2;
    localparam int CC_SYSCLK_OFF     = 1;
    localparam int CC_QUADCLK_OFF    = 0;

    // Slip interval field positions
    localparam int SI_EXT_REF        = 6;
    localparam int SI_NEAR_FAR       = 5;
    localparam int SI_INTERVAL_HI    = 4;
    localparam int SI_INTERVAL_LO    = 0;

    // Timing
    localparam int CLK_PERIOD_NS     = 50;
    localparam int SLIP_UNIT_NS      = 2000;
    localparam int SLIP_TARGET_NS    = 62500;
    localparam int FRAME_NS          = 125000;
    localparam logic [11:0] SLIP_UNIT_CYC   = 12'(SLIP_UNIT_NS / CLK_PERIOD_NS);
    localparam logic [11:0] SLIP_TARGET_CYC = 12'(SLIP_TARGET_NS / CLK_PERIOD_NS);
    localparam logic [11:0] FRAME_CYC       = 12'(FRAME_NS / CLK_PERIOD_NS);
    localparam int QUAD_DIV_CYC      = 4;

endpackage

// ---- rtl/pfa_frame_align.sv ----
// Frame timing, slip control, clock select and stream alignment with APB registers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module pfa_frame_align
(
    input  logic              clk,
    input  logic              rst_n,
    input  logic              psel,
    input  logic              penable,
    input  logic              pwrite,
    input  pfa_pkg::addr_t    paddr,
    input  pfa_pkg::data_t    pwdata,
    output pfa_pkg::data_t    prdata,
    output logic              pready,
    output logic              pslverr,
    input  logic              highwayBitClock,
    input  logic              frameSyncInput,
    input  logic              receiveInData,
    input  logic              nearReferenceClock,
    input  logic              farReferenceClock,
    input  logic              externalReferenceClock,
    input  logic              nearBufferSyncPulse,
    input  logic              farBufferSyncPulse,
    output logic              pllReferenceClock,
    output logic              frameSyncOutput,
    output logic              frameSlip,
    output logic              vcoControlPin,
    output logic              systemClockOutput,
    output logic              quadClockOutput,
    output logic              receiveInSample,
    output logic              syncDetected,
    output logic [7:0]        receiveInPosition,
    output logic [7:0]        sendInPosition,
    output logic [7:0]        sendOutPosition,
    output logic [7:0]        auxPosition,
    output logic [7:0]        streamPhases
);
    import pfa_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [6:0] clockControl;
    logic [6:0] slipInterval;
    logic [7:0] receiveInOffset;
    logic [7:0] sendInOffset;
    logic [7:0] sendOutOffset;
    logic [7:0] auxOffset;
    logic [7:0] phaseOffsets;
    logic [7:0] regIndex;
    logic       indexValid;
    logic [7:0] readValue;
    logic       setupPhase;
    logic       accessDone;
    // Unaligned addresses are not mapped
    assign regIndex   = {2'b00, paddr[7:2]};
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;

    always_comb
    begin
        indexValid = (paddr[1:0] == 2'b00);
        readValue  = 8'h00;
        case (regIndex)
            IDX_CLOCK_CONTROL:  readValue = {1'b0, clockControl};
            IDX_SLIP_INTERVAL:  readValue = {1'b0, slipInterval};
            IDX_RECEIVE_IN_OFS: readValue = receiveInOffset;
            IDX_SEND_IN_OFS:    readValue = sendInOffset;
            IDX_SEND_OUT_OFS:   readValue = sendOutOffset;
            IDX_AUX_OFS:        readValue = auxOffset;
            IDX_PHASE_OFS:      readValue = phaseOffsets;
            default:            indexValid = 1'b0;
        endcase
    end

    // Answer is prepared in setup and given in the first access cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !indexValid;
            if (setupPhase)
                prdata <= (indexValid && !pwrite) ? {24'h000000, readValue} : '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clockControl    <= RST_CLOCK_CONTROL;
            slipInterval    <= RST_SLIP_INTERVAL;
            receiveInOffset <= RST_BIT_OFFSET;
            sendInOffset    <= RST_BIT_OFFSET;
            sendOutOffset   <= RST_BIT_OFFSET;
            auxOffset       <= RST_BIT_OFFSET;
            phaseOffsets    <= RST_PHASE_OFS;
        end
        else if (accessDone && pwrite && indexValid)
        begin
            case (regIndex)
                IDX_CLOCK_CONTROL:  clockControl    <= pwdata[6:0];
                IDX_SLIP_INTERVAL:  slipInterval    <= pwdata[6:0];
                IDX_RECEIVE_IN_OFS: receiveInOffset <= pwdata[7:0];
                IDX_SEND_IN_OFS:    sendInOffset    <= pwdata[7:0];
                IDX_SEND_OUT_OFS:   sendOutOffset   <= pwdata[7:0];
                IDX_AUX_OFS:        auxOffset       <= pwdata[7:0];
                IDX_PHASE_OFS:      phaseOffsets    <= pwdata[7:0];
                default:            clockControl    <= clockControl;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int PINS = 8;
    logic [PINS-1:0] pinRaw;
    logic [PINS-1:0] pinMeta;
    logic [PINS-1:0] pinSync;
    logic            bitClockLast;
    logic            bufferSyncLast;
    assign pinRaw = {highwayBitClock, frameSyncInput, receiveInData, nearReferenceClock,
                     farReferenceClock, externalReferenceClock, nearBufferSyncPulse,
                     farBufferSyncPulse};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else
        begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    logic bitClk;
    logic syncIn;
    logic dataIn;
    logic refNear;
    logic refFar;
    logic refExt;
    logic bufNear;
    logic bufFar;
    assign {bitClk, syncIn, dataIn, refNear, refFar, refExt, bufNear, bufFar} = pinSync;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference and buffer sync selection
    logic selectedBufferSync;
    logic bufferSyncEdge;
    assign selectedBufferSync = slipInterval[SI_NEAR_FAR] ? bufNear : bufFar;
    assign bufferSyncEdge     = selectedBufferSync && !bufferSyncLast;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pllReferenceClock <= 1'b0;
        else if (slipInterval[SI_EXT_REF])
            pllReferenceClock <= refExt;
        else
            pllReferenceClock <= slipInterval[SI_NEAR_FAR] ? refNear : refFar;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame counter, sync output and frame slip
    logic [11:0] frameCnt;
    logic [11:0] distAfter;
    logic [11:0] distBefore;
    logic [11:0] minDistance;
    logic [11:0] safetyCycles;
    logic        slipNeeded;
    logic        bitRise;
    logic [1:0]  syncOutLeft;
    assign distAfter    = frameCnt;
    assign distBefore   = FRAME_CYC - frameCnt;
    assign minDistance  = (distAfter < distBefore) ? distAfter : distBefore;
    assign safetyCycles = 12'(slipInterval[SI_INTERVAL_HI:SI_INTERVAL_LO] * SLIP_UNIT_CYC);
    assign slipNeeded   = bufferSyncEdge && (minDistance < safetyCycles);
    assign bitRise      = bitClk && !bitClockLast;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            frameCnt       <= '0;
            frameSlip      <= 1'b0;
            bufferSyncLast <= 1'b0;
        end
        else
        begin
            bufferSyncLast <= selectedBufferSync;
            frameSlip      <= slipNeeded;
            if (slipNeeded)
                frameCnt <= FRAME_CYC - SLIP_TARGET_CYC;
            else if (frameCnt == FRAME_CYC - 12'h001)
                frameCnt <= '0;
            else
                frameCnt <= frameCnt + 12'h001;
        end
    end

    // Pulse length counted in highway bit clock periods
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            syncOutLeft     <= 2'b00;
            frameSyncOutput <= 1'b0;
        end
        else
        begin
            if (frameCnt == 12'h000)
                syncOutLeft <= clockControl[CC_SYNC_OUT_LEN] ? 2'b10 : 2'b01;
            else if (bitRise && syncOutLeft != 2'b00)
                syncOutLeft <= syncOutLeft - 2'b01;
            frameSyncOutput <= (frameCnt == 12'h000) || (syncOutLeft != 2'b00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock outputs
    logic [1:0] quadDiv;
    logic       sysToggle;
    logic       quadToggle;
    logic       phaseError;
    assign phaseError = pllReferenceClock ^ (frameCnt < (FRAME_CYC >> 1));
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sysToggle         <= 1'b0;
            quadToggle        <= 1'b0;
            quadDiv           <= 2'b00;
            systemClockOutput <= 1'b1;
            quadClockOutput   <= 1'b1;
            vcoControlPin     <= 1'b1;
        end
        else
        begin
            sysToggle <= !sysToggle;
            quadDiv   <= quadDiv + 2'b01;
            if (quadDiv == 2'(QUAD_DIV_CYC - 1))
                quadToggle <= !quadToggle;
            systemClockOutput <= clockControl[CC_SYSCLK_OFF] ? 1'b1 : sysToggle;
            quadClockOutput   <= clockControl[CC_QUADCLK_OFF] ? 1'b1 : quadToggle;
            vcoControlPin     <= clockControl[CC_VCO_OFF] ? 1'b1 :
                                 (phaseError ^ clockControl[CC_VCO_INVERT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sampling edge and frame sync detection
    logic sampleEdge;
    logic syncSample;
    logic syncActive;
    assign sampleEdge = clockControl[CC_SAMPLE_EDGE] ? bitRise : (!bitClk && bitClockLast);
    assign syncActive = sampleEdge && (syncIn != syncSample)
                        && (syncIn == clockControl[CC_SYNC_EDGE]);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bitClockLast    <= 1'b0;
            syncSample      <= 1'b0;
            receiveInSample <= 1'b0;
            syncDetected    <= 1'b0;
        end
        else
        begin
            bitClockLast  <= bitClk;
            syncDetected  <= syncActive;
            if (sampleEdge)
            begin
                syncSample      <= syncIn;
                receiveInSample <= dataIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-stream bit position and phase
    logic [7:0] offsetOf [4];
    logic [7:0] position [4];
    logic [1:0] phase    [4];
    assign offsetOf[0] = receiveInOffset;
    assign offsetOf[1] = sendInOffset;
    assign offsetOf[2] = sendOutOffset;
    assign offsetOf[3] = auxOffset;
    genvar s;
    generate
        for (s = 0; s < 4; s++)
        begin : gStream
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    position[s] <= 8'h00;
                    phase[s]    <= 2'b00;
                end
                else if (syncActive)
                begin
                    position[s] <= offsetOf[s];
                    phase[s]    <= phaseOffsets[2*s +: 2];
                end
                else if (sampleEdge)
                begin
                    phase[s] <= phase[s] + 2'b01;
                    if (phase[s] == 2'b11)
                        position[s] <= position[s] + 8'h01;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            receiveInPosition <= 8'h00;
            sendInPosition    <= 8'h00;
            sendOutPosition   <= 8'h00;
            auxPosition       <= 8'h00;
            streamPhases      <= 8'h00;
        end
        else
        begin
            receiveInPosition <= position[0];
            sendInPosition    <= position[1];
            sendOutPosition   <= position[2];
            auxPosition       <= position[3];
            streamPhases      <= {phase[3], phase[2], phase[1], phase[0]};
        end
    end

endmodule

// ---- verif/pfa_highway_model.sv ----
// Behavioural PCM highway side: bit clock, frame sync, data and reference clocks
`timescale 1ns/10ps
module pfa_highway_model
#(
    parameter int FRAME_BITS = 64
)
(
    input  wire logic syncRising,
    output logic      highwayBitClock,
    output logic      frameSyncInput,
    output logic      receiveInData,
    output logic      nearReferenceClock,
    output logic      farReferenceClock,
    output logic      externalReferenceClock
);
    int bitCnt;
    initial
    begin
        highwayBitClock = 1'b0;
        frameSyncInput = 1'b1;
        receiveInData = 1'b0;
        nearReferenceClock = 1'b0;
        farReferenceClock = 1'b1;
        externalReferenceClock = 1'b0;
        bitCnt = 0;
        #37;
        forever
            #200 highwayBitClock = ~highwayBitClock;
    end
    // Distinct periods so a wrong reference choice is visible
    always #700 nearReferenceClock = ~nearReferenceClock;
    always #900 farReferenceClock = ~farReferenceClock;
    always #1100 externalReferenceClock = ~externalReferenceClock;
    // Sync moves mid-bit so it straddles both possible sampling edges
    always @(posedge highwayBitClock)
    begin
        #100;
        frameSyncInput = (bitCnt == 0) ? syncRising : !syncRising;
        receiveInData = bitCnt[0] ^ bitCnt[3];
        bitCnt = (bitCnt + 1) % FRAME_BITS;
    end
endmodule

// ---- verif/pfa_frame_align_monitor.sv ----
// Port-level assertions for the frame alignment block
`timescale 1ns/10ps
module pfa_frame_align_monitor
(
    input wire logic           clk,
    input wire logic           rst_n,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire pfa_pkg::addr_t paddr,
    input wire pfa_pkg::data_t pwdata,
    input wire pfa_pkg::data_t prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic           nearReferenceClock,
    input wire logic           farReferenceClock,
    input wire logic           externalReferenceClock,
    input wire logic           pllReferenceClock,
    input wire logic           frameSyncOutput,
    input wire logic           frameSlip,
    input wire logic           vcoControlPin,
    input wire logic           systemClockOutput,
    input wire logic           quadClockOutput
);
    import pfa_pkg::*;
    logic [6:0]  slip;
    logic [6:0]  cc;
    logic [11:0] age;
    logic        seen;
    logic        slipped;
    logic        wr;
    assign wr = psel && penable && pready && pwrite && !pslverr;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Shadow registers and time since the last sync or slip
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            slip <= 7'h28;
        else if (wr && paddr == 8'h30)
            slip <= pwdata[6:0];
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cc <= 7'h00;
        else if (wr && paddr == 8'h2c)
            cc <= pwdata[6:0];
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n || frameSlip || $rose(frameSyncOutput))
            age <= 12'h000;
        else
            age <= age + {11'h000, age != 12'hfff};
        seen <= rst_n && (seen || $rose(frameSyncOutput));
        slipped <= rst_n && (frameSlip || (slipped && !$rose(frameSyncOutput)));
    end
    ////////////////////////////////////////////////////////////////////////
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_bad_addr: assert property (psel && !penable && (paddr[1:0] != 2'b00
        || paddr < 8'h2c || paddr > 8'h44) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ext_ref:
        assert property ((slip[6] && externalReferenceClock) [*6] |-> pllReferenceClock)
        else $error("external reference not used");
    a_near_ref:
        assert property ((slip[6:5] == 2'b01 && !nearReferenceClock) [*6] |-> !pllReferenceClock)
        else $error("near reference not used");
    a_far_ref:
        assert property ((slip[6:5] == 2'b00 && farReferenceClock) [*6] |-> pllReferenceClock)
        else $error("far reference not used");
    a_sys_off:
        assert property (cc[1] [*4] |-> systemClockOutput)
        else $error("system clock not held high");
    a_sys_runs:
        assert property (!cc[1] [*4] |-> systemClockOutput != $past(systemClockOutput))
        else $error("system clock not toggling");
    a_quad_off:
        assert property (cc[0] [*4] |-> quadClockOutput)
        else $error("quad clock not held high");
    a_vco_off:
        assert property (cc[2] [*4] |-> vcoControlPin)
        else $error("vco control not held high");
    a_slip_space:
        assert property ($rose(frameSyncOutput) && seen |-> (slipped ?
            age inside {[1240:1280]} : age inside {[2475:2525]}))
        else $error("frame sync spacing wrong");
endmodule
bind pfa_frame_align pfa_frame_align_monitor i_pfa_frame_align_monitor (.*);

// ---- verif/pfa_frame_align_test.sv ----
// Self-checking bench for the frame alignment block
`timescale 1ns/10ps
module pfa_frame_align_test;
    import pfa_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, syncRising, er, lo, hit;
    logic        highwayBitClock, frameSyncInput, receiveInData, receiveInSample;
    logic        nearReferenceClock, farReferenceClock, externalReferenceClock;
    logic        nearBufferSyncPulse, farBufferSyncPulse, pready, pslverr;
    logic        pllReferenceClock, frameSyncOutput, frameSlip, syncDetected;
    logic        vcoControlPin, systemClockOutput, quadClockOutput;
    logic [7:0]  receiveInPosition, sendInPosition, sendOutPosition, auxPosition;
    logic [7:0]  streamPhases, ePh;
    logic [31:0] ePos, d;
    addr_t       paddr;
    data_t       pwdata, prdata, rd;
    int          fail_count, n_checks, k;
    int          slipTbl[7][4] = '{'{40, 100, 1, 1}, '{40, 1000, 1, 0}, '{40, 100, 0, 0},
        '{8, 100, 0, 1}, '{8, 100, 1, 0}, '{63, 1000, 1, 1}, '{32, 100, 1, 0}};
    pfa_frame_align i_pfa_frame_align (.*);
    pfa_highway_model i_pfa_highway_model (.*);
    initial
    begin
        clk = 1'b0;
        forever
            #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A spent wait bound counts as a mismatch and ends the run
    task automatic guard(input logic ok);
        if (ok !== 1'b1)
        begin
            fail_count++;
            results();
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        guard(pready);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, psel, penable, pwrite, syncRising} = 5'h0;
        {nearBufferSyncPulse, farBufferSyncPulse} = 2'h0;
        paddr = '0;
        pwdata = '0;
        fail_count = 0;
        n_checks = 0;
        void'($urandom(68472));
        repeat (3) @(posedge clk);
        check({systemClockOutput, quadClockOutput, vcoControlPin, frameSyncOutput}, 4'he);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, 8'h2c + 8'(4 * i), 32'h0);
            check(rd, i == 1 ? 32'h28 : 32'h0);
            d = $urandom;
            apb(1'b1, 8'h2c + 8'(4 * i), d);
            apb(1'b0, 8'h2c + 8'(4 * i), 32'h0);
            check(rd, d & (i < 2 ? 32'h7f : 32'hff));
        end
        apb(1'b0, 8'h48, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, 8'h31, 32'hff);
        check(er, 1'b1);
        $display("test registers done");
        for (int r = 0; r < 3; r++)
        begin
            ePh = r == 1 ? 8'hff : 8'($urandom);
            ePos = r == 1 ? 32'hffffffff : $urandom;
            syncRising <= r == 1;
            apb(1'b1, 8'h2c, r == 0 ? 32'h0 : r == 1 ? 32'h28 : 32'h08);
            for (int s = 0; s < 4; s++)
                apb(1'b1, 8'h34 + 8'(4 * s), {24'h0, ePos[8 * s +: 8]});
            apb(1'b1, 8'h44, {24'h0, ePh});
            k = 0;
            while (syncDetected !== 1'b1 && k < 2000)
            begin
                @(posedge clk);
                k++;
            end
            guard(syncDetected);
            repeat (3) @(posedge clk);
            check({auxPosition, sendOutPosition, sendInPosition, receiveInPosition}, ePos);
            check(streamPhases, ePh);
            check(receiveInSample, 1'b0);
            k = 0;
            while (streamPhases === ePh && k < 40)
            begin
                @(posedge clk);
                k++;
            end
            guard(k < 40);
            // Second sampled bit of the highway pattern is a one
            check(receiveInSample, 1'b1);
            for (int s = 0; s < 4; s++)
            begin
                if (ePh[2 * s +: 2] == 2'd3)
                    ePos[8 * s +: 8] += 8'h01;
                ePh[2 * s +: 2] += 2'd1;
            end
            check({auxPosition, sendOutPosition, sendInPosition, receiveInPosition}, ePos);
            check(streamPhases, ePh);
        end
        $display("test alignment done");
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, 8'h30, i == 0 ? 32'h28 : i == 1 ? 32'h08 : 32'h48);
            repeat (1500) @(posedge clk);
        end
        apb(1'b1, 8'h2c, 32'h07);
        repeat (4) @(posedge clk);
        check({systemClockOutput, quadClockOutput, vcoControlPin}, 3'h7);
        apb(1'b1, 8'h2c, 32'h00);
        $display("test clocks done");
        for (int t = 0; t < 7; t++)
        begin
            apb(1'b1, 8'h30, slipTbl[t][0]);
            k = 0;
            do
            begin
                lo = frameSyncOutput;
                @(posedge clk);
                k++;
            end
            while (!(frameSyncOutput === 1'b1 && lo === 1'b0) && k < 3000);
            guard(k < 3000);
            repeat (slipTbl[t][1]) @(posedge clk);
            if (slipTbl[t][2] != 0)
                nearBufferSyncPulse <= 1'b1;
            else
                farBufferSyncPulse <= 1'b1;
            hit = 1'b0;
            for (int j = 0; j < 30; j++)
            begin
                @(posedge clk);
                hit = hit | (frameSlip === 1'b1);
                if (j == 3)
                    {nearBufferSyncPulse, farBufferSyncPulse} <= 2'h0;
            end
            check(hit, slipTbl[t][3]);
        end
        $display("test slip done");
        results();
    end
endmodule
